// [rtl/irq_ctrl_pkg.sv]
// constants and types shared by the four-level interrupt controller
package irq_ctrl_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_SRC = 4;
  localparam int LVL_W = 2;
  localparam int VEC_W = 16;
  localparam int PHASE_W = 4;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ENABLE_ADDR = 8'ha8;
  localparam logic [ADDR_W-1:0] PRIO_LOWER_ADDR = 8'hb8;
  localparam logic [ADDR_W-1:0] PRIO_UPPER_ADDR = 8'hb7;
  localparam logic [ADDR_W-1:0] FLAG_ADDR = 8'h88;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'hc0;

  localparam logic [DATA_W-1:0] ENABLE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] PRIO_RESET = 8'h00;
  localparam logic [DATA_W-1:0] FLAG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int GATE_BIT = 7;
  localparam int TRIG_A_BIT = 4;
  localparam int TRIG_B_BIT = 5;
  localparam int STATUS_CALL_BIT = 4;

  // source index doubles as enable, priority and flag bit position
  localparam int SRC_PIN_A = 0;
  localparam int SRC_TIMER = 1;
  localparam int SRC_PIN_B = 2;
  localparam int SRC_HIGHBYTE = 3;

  // ----------------------------------------------------------------
  // vectors and machine-cycle timing
  // ----------------------------------------------------------------
  localparam logic [VEC_W-1:0] VEC_BASE = 16'h0003;
  localparam int VEC_STRIDE_SHIFT = 3;
  localparam int PHASES_PER_MCYCLE = 12;
  localparam int SAMPLE_PHASE = 9;

  typedef enum logic [1:0] {
    CALL_IDLE,
    CALL_FIRST,
    CALL_SECOND
  } call_state_t;

endpackage

// [rtl/four_level_irq_controller.sv]
// four-source, four-level interrupt controller with machine-cycle polling
`timescale 1ns/1ps

// Functional notes
// - global gate clear blocks all; set passes sources whose enable bit is set
// - level is {lower bit, upper bit}: 00=0, 01=1, 10=2, 11=3 highest
// - running routine preempted only by strictly higher pending level
// - routine at highest level is never preempted
// - highest pending level is served first
// - equal level ties: pin a, timer, pin b, high-byte overflow
// - flags captured at the sample point, evaluated at the end of the same machine cycle
// - no call while equal or higher level routine is in progress
// - call issued only when polling cycle is the instruction's last cycle
// - after return or enable/priority write, one more instruction runs first
// - blocked level request gone inactive is forgotten
// - vectors 0003, 000b, 0013, 001b by source
// - on grant core pushes program counter and loads the vector
// - return clears current in-progress level; core pops two bytes
// - pin levels inverted and latched into flags at the sample point
// - call lasts two machine cycles; three cycles minimum to first instruction
// - single-source latency above 3 and below 9 machine cycles
// - trigger type 0 requests on low level, 1 on falling edge
// - timer and edge flags cleared on vectoring; level flags follow pin
module four_level_irq_controller
#(
  parameter int PHASES = irq_ctrl_pkg::PHASES_PER_MCYCLE,
  parameter int SAMPLE_AT = irq_ctrl_pkg::SAMPLE_PHASE
)
(
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [irq_ctrl_pkg::ADDR_W-1:0] addr_in,
  input wire logic [irq_ctrl_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [irq_ctrl_pkg::DATA_W-1:0] rdata_out,
  input wire logic ext_request_pin_a_in,
  input wire logic ext_request_pin_b_in,
  input wire logic timer_overflow_in,
  input wire logic highbyte_overflow_in,
  input wire logic instr_last_cycle_in,
  input wire logic return_from_interrupt_in,
  output logic sample_point_out,
  output logic machine_cycle_end_out,
  output logic hardware_long_call_out,
  output logic call_start_out,
  output logic [irq_ctrl_pkg::VEC_W-1:0] vector_addr_out,
  output logic [irq_ctrl_pkg::NUM_SRC-1:0] in_progress_out
);
  import irq_ctrl_pkg::*;

  if (PHASES < 2 || PHASES > 16 || SAMPLE_AT < 0 || SAMPLE_AT >= PHASES)
  begin : bad_timing
    $error("machine cycle phases or sample phase out of range");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [LVL_W-1:0] level_of(input logic [DATA_W-1:0] lower,
                                                input logic [DATA_W-1:0] upper,
                                                input int idx);
    level_of = {lower[idx], upper[idx]};
  endfunction

  // returns {found, index}; strict compare keeps the lowest index among ties
  function automatic logic [LVL_W:0] pick_source(input logic [NUM_SRC-1:0] cand,
                                                 input logic [2*NUM_SRC-1:0] lvls);
    logic found;
    logic [LVL_W-1:0] best_lvl;
    logic [LVL_W-1:0] best_idx;
    found = 1'b0;
    best_lvl = '0;
    best_idx = '0;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (cand[i] && (!found || lvls[2*i +: 2] > best_lvl))
      begin
        found = 1'b1;
        best_lvl = lvls[2*i +: 2];
        best_idx = LVL_W'(i);
      end
    end
    pick_source = {found, best_idx};
  endfunction

  // returns {any, highest set level}
  function automatic logic [LVL_W:0] top_level(input logic [NUM_SRC-1:0] bits);
    logic any;
    logic [LVL_W-1:0] lvl;
    any = 1'b0;
    lvl = '0;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (bits[i])
      begin
        any = 1'b1;
        lvl = LVL_W'(i);
      end
    end
    top_level = {any, lvl};
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [PHASE_W-1:0] phase_reg;
  logic [PHASE_W-1:0] phase_next;
  logic [DATA_W-1:0] enable_reg;
  logic [DATA_W-1:0] prio_lower_reg;
  logic [DATA_W-1:0] prio_upper_reg;
  logic [NUM_SRC-1:0] flag_reg;
  logic [NUM_SRC-1:0] flag_next;
  logic trig_a_reg;
  logic trig_b_reg;
  logic pin_a_prev_reg;
  logic pin_b_prev_reg;
  logic [NUM_SRC-1:0] poll_reg;
  logic [NUM_SRC-1:0] prog_reg;
  logic [NUM_SRC-1:0] prog_next;
  logic hold_reg;
  logic hold_next;
  call_state_t call_state_reg;
  call_state_t call_state_next;
  logic call_start_reg;
  logic [VEC_W-1:0] vector_reg;
  logic [DATA_W-1:0] rdata_reg;

  // ----------------------------------------------------------------
  // machine-cycle divider
  // ----------------------------------------------------------------
  wire logic sample_tick = (phase_reg == PHASE_W'(SAMPLE_AT));
  wire logic cycle_end = (phase_reg == PHASE_W'(PHASES - 1));

  assign phase_next = cycle_end ? '0 : phase_reg + PHASE_W'(1);

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  wire logic wr_enable = wr_in && (addr_in == ENABLE_ADDR);
  wire logic wr_lower = wr_in && (addr_in == PRIO_LOWER_ADDR);
  wire logic wr_upper = wr_in && (addr_in == PRIO_UPPER_ADDR);
  wire logic wr_flag = wr_in && (addr_in == FLAG_ADDR);
  wire logic cfg_write = wr_enable || wr_lower || wr_upper;

  logic [DATA_W-1:0] read_mux;
  wire logic [DATA_W-1:0] flag_view = {2'b00, trig_b_reg, trig_a_reg, flag_reg};
  wire logic [DATA_W-1:0] status_view = {3'b000, (call_state_reg != CALL_IDLE), prog_reg};

  always_comb
  begin
    if (addr_in == ENABLE_ADDR)
      read_mux = enable_reg;
    else if (addr_in == PRIO_LOWER_ADDR)
      read_mux = prio_lower_reg;
    else if (addr_in == PRIO_UPPER_ADDR)
      read_mux = prio_upper_reg;
    else if (addr_in == FLAG_ADDR)
      read_mux = flag_view;
    else if (addr_in == STATUS_ADDR)
      read_mux = status_view;
    else
      read_mux = READ_IDLE;
  end

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  // pins are looked at only at the sample point, so glitches between are ignored
  wire logic fall_a = pin_a_prev_reg && !ext_request_pin_a_in;
  wire logic fall_b = pin_b_prev_reg && !ext_request_pin_b_in;

  // ----------------------------------------------------------------
  // polling and arbitration
  // ----------------------------------------------------------------
  wire logic gate = enable_reg[GATE_BIT];
  wire logic [LVL_W:0] active = top_level(prog_reg);
  wire logic any_active = active[LVL_W];
  wire logic [LVL_W-1:0] active_lvl = active[LVL_W-1:0];

  logic [2*NUM_SRC-1:0] src_lvls;
  logic [NUM_SRC-1:0] eligible;

  always_comb
  begin
    for (int i = 0; i < NUM_SRC; i++)
    begin
      src_lvls[2*i +: 2] = level_of(prio_lower_reg, prio_upper_reg, i);
      // level 3 can never exceed an active level 3, so it is never preempted
      eligible[i] = poll_reg[i] && gate && enable_reg[i]
                    && (!any_active || src_lvls[2*i +: 2] > active_lvl);
    end
  end

  wire logic [LVL_W:0] choice = pick_source(eligible, src_lvls);
  wire logic found = choice[LVL_W];
  wire logic [LVL_W-1:0] chosen = choice[LVL_W-1:0];
  wire logic [LVL_W-1:0] chosen_lvl = src_lvls[2*chosen +: 2];

  wire logic hold_now = hold_reg || return_from_interrupt_in || cfg_write;
  wire logic poll_point = cycle_end && (call_state_reg == CALL_IDLE) && instr_last_cycle_in;
  wire logic grant = poll_point && found && !hold_now;
  wire logic [NUM_SRC-1:0] grant_onehot = grant ? (NUM_SRC'(1) << chosen) : '0;

  // hold spans the rest of the instruction that returned or rewrote configuration
  always_comb
  begin
    if (poll_point)
      hold_next = 1'b0;
    else
      hold_next = hold_now;
  end

  // ----------------------------------------------------------------
  // request flags
  // ----------------------------------------------------------------
  // order below: hardware clear, then software write, then hardware set wins
  always_comb
  begin
    flag_next = flag_reg;
    if (!trig_a_reg)
      flag_next[SRC_PIN_A] = flag_reg[SRC_PIN_A];
    else if (grant_onehot[SRC_PIN_A])
      flag_next[SRC_PIN_A] = 1'b0;
    if (!trig_b_reg)
      flag_next[SRC_PIN_B] = flag_reg[SRC_PIN_B];
    else if (grant_onehot[SRC_PIN_B])
      flag_next[SRC_PIN_B] = 1'b0;
    if (grant_onehot[SRC_TIMER])
      flag_next[SRC_TIMER] = 1'b0;
    if (grant_onehot[SRC_HIGHBYTE])
      flag_next[SRC_HIGHBYTE] = 1'b0;
    if (wr_flag)
      flag_next = wdata_in[NUM_SRC-1:0];
    if (sample_tick)
    begin
      if (!trig_a_reg)
        flag_next[SRC_PIN_A] = !ext_request_pin_a_in;
      else if (fall_a)
        flag_next[SRC_PIN_A] = 1'b1;
      if (!trig_b_reg)
        flag_next[SRC_PIN_B] = !ext_request_pin_b_in;
      else if (fall_b)
        flag_next[SRC_PIN_B] = 1'b1;
    end
    if (timer_overflow_in)
      flag_next[SRC_TIMER] = 1'b1;
    if (highbyte_overflow_in)
      flag_next[SRC_HIGHBYTE] = 1'b1;
  end

  // ----------------------------------------------------------------
  // in-progress levels and call sequence
  // ----------------------------------------------------------------
  wire logic [NUM_SRC-1:0] return_from_interrupt_clear =
    (return_from_interrupt_in && any_active) ? (NUM_SRC'(1) << active_lvl) : '0;

  assign prog_next = (prog_reg & ~return_from_interrupt_clear) | (grant ? (NUM_SRC'(1) << chosen_lvl) : '0);

  wire logic [VEC_W-1:0] chosen_vector =
    VEC_BASE + (VEC_W'(chosen) << VEC_STRIDE_SHIFT);

  always_comb
  begin
    call_state_next = call_state_reg;
    case (call_state_reg)
      CALL_IDLE:
      begin
        if (grant)
          call_state_next = CALL_FIRST;
      end
      CALL_FIRST:
      begin
        if (cycle_end)
          call_state_next = CALL_SECOND;
      end
      CALL_SECOND:
      begin
        if (cycle_end)
          call_state_next = CALL_IDLE;
      end
      default:
      begin
        call_state_next = CALL_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      phase_reg <= '0;
      call_state_reg <= CALL_IDLE;
      hold_reg <= 1'b0;
      prog_reg <= '0;
      call_start_reg <= 1'b0;
      vector_reg <= '0;
    end
    else
    begin
      phase_reg <= phase_next;
      call_state_reg <= call_state_next;
      hold_reg <= hold_next;
      prog_reg <= prog_next;
      call_start_reg <= grant;
      if (grant)
        vector_reg <= chosen_vector;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      enable_reg <= ENABLE_RESET;
      prio_lower_reg <= PRIO_RESET;
      prio_upper_reg <= PRIO_RESET;
      trig_a_reg <= 1'b0;
      trig_b_reg <= 1'b0;
    end
    else
    begin
      if (wr_enable)
        enable_reg <= {wdata_in[GATE_BIT], 3'b000, wdata_in[NUM_SRC-1:0]};
      if (wr_lower)
        prio_lower_reg <= {4'h0, wdata_in[NUM_SRC-1:0]};
      if (wr_upper)
        prio_upper_reg <= {4'h0, wdata_in[NUM_SRC-1:0]};
      if (wr_flag)
      begin
        trig_a_reg <= wdata_in[TRIG_A_BIT];
        trig_b_reg <= wdata_in[TRIG_B_BIT];
      end
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      flag_reg <= FLAG_RESET[NUM_SRC-1:0];
      poll_reg <= '0;
      pin_a_prev_reg <= 1'b1;
      pin_b_prev_reg <= 1'b1;
      rdata_reg <= READ_IDLE;
    end
    else
    begin
      flag_reg <= flag_next;
      if (sample_tick)
      begin
        poll_reg <= flag_next;
        pin_a_prev_reg <= ext_request_pin_a_in;
        pin_b_prev_reg <= ext_request_pin_b_in;
      end
      rdata_reg <= rd_in ? read_mux : READ_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_out = rdata_reg;
  assign sample_point_out = sample_tick;
  assign machine_cycle_end_out = cycle_end;
  assign hardware_long_call_out = (call_state_reg != CALL_IDLE);
  assign call_start_out = call_start_reg;
  assign vector_addr_out = vector_reg;
  assign in_progress_out = prog_reg;

endmodule

// [tb/irq_props.sv]
// port-level checks for the interrupt controller
`timescale 1ns/1ps
module irq_props
  import irq_ctrl_pkg::*;
#(
  parameter int PHASES = PHASES_PER_MCYCLE,
  parameter int SAMPLE_AT = SAMPLE_PHASE
)
(
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [irq_ctrl_pkg::ADDR_W-1:0] addr_in,
  input wire logic [irq_ctrl_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic instr_last_cycle_in,
  input wire logic return_from_interrupt_in,
  input wire logic sample_point_out,
  input wire logic machine_cycle_end_out,
  input wire logic hardware_long_call_out,
  input wire logic call_start_out,
  input wire logic [irq_ctrl_pkg::VEC_W-1:0] vector_addr_out,
  input wire logic [irq_ctrl_pkg::NUM_SRC-1:0] in_progress_out
);
  localparam int GAP = PHASES - 1 - SAMPLE_AT;
  localparam int CALL_LEN = 2 * PHASES;
  logic [7:0] en_reg, lo_reg, up_reg, len_reg;
  logic held_reg;
  wire logic [1:0] src = vector_addr_out[4:3];
  wire logic [1:0] lvl = {lo_reg[src], up_reg[src]};
  wire logic cfg_wr = wr_in & (addr_in == ENABLE_ADDR | addr_in == PRIO_LOWER_ADDR | addr_in == PRIO_UPPER_ADDR);
  wire logic hold_ev = return_from_interrupt_in | cfg_wr;

  function automatic logic [3:0] drop_top(input logic [3:0] v);
    return v[3] ? {1'b0, v[2:0]} : v[2] ? {2'b0, v[1:0]} : v[1] ? {3'b0, v[0]} : 4'h0;
  endfunction

  // shadow copies let the checks know gate, masks and levels
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      en_reg <= ENABLE_RESET;
      lo_reg <= PRIO_RESET;
      up_reg <= PRIO_RESET;
      len_reg <= 8'h00;
      held_reg <= 1'b0;
    end
    else
    begin
      if (wr_in && addr_in == ENABLE_ADDR)
        en_reg <= wdata_in;
      if (wr_in && addr_in == PRIO_LOWER_ADDR)
        lo_reg <= wdata_in;
      if (wr_in && addr_in == PRIO_UPPER_ADDR)
        up_reg <= wdata_in;
      len_reg <= hardware_long_call_out ? len_reg + 8'h01 : 8'h00;
      held_reg <= machine_cycle_end_out ? 1'b0 : held_reg | hold_ev;
    end
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_poll_grant;
    machine_cycle_end_out ##1 call_start_out;
  endsequence

  chk_sample_end: assert property (sample_point_out |-> ##GAP machine_cycle_end_out)
    else $error("cycle end not after sample point");
  chk_grant_last: assert property (s_poll_grant |-> $past(instr_last_cycle_in))
    else $error("call granted outside last cycle");
  chk_start_edge: assert property (call_start_out |-> $past(machine_cycle_end_out) && hardware_long_call_out)
    else $error("call start not after cycle end");
  chk_call_len: assert property ($fell(hardware_long_call_out) |-> len_reg == CALL_LEN)
    else $error("call length wrong");
  chk_vector_map: assert property (call_start_out |-> vector_addr_out[2:0] == 3'h3 && vector_addr_out[15:5] == 11'h000)
    else $error("vector outside table");
  chk_gate_mask: assert property (call_start_out |-> en_reg[GATE_BIT] && en_reg[src])
    else $error("call for a blocked source");
  chk_level_block: assert property (call_start_out |-> ($past(in_progress_out) >> lvl) == 4'h0)
    else $error("call at or below running level");
  chk_mark_level: assert property (call_start_out |-> ##[0:1] in_progress_out[lvl])
    else $error("level not marked in progress");
  chk_hold_block: assert property (machine_cycle_end_out && (held_reg || hold_ev) |=> !call_start_out)
    else $error("call during hold");
  chk_ret_pop: assert property (return_from_interrupt_in && !call_start_out |=>
    in_progress_out == drop_top($past(in_progress_out)))
    else $error("return cleared wrong level");
endmodule

// [tb/core_model.sv]
// behavioural processor core answering the controller's calls
`timescale 1ns/1ps
module core_model
(
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic cycle_end_in,
  input wire logic call_start_in,
  input wire logic [15:0] vector_in,
  input wire logic [2:0] instr_len_in,
  input wire logic ret_req_in,
  output logic last_cycle_out,
  output logic ret_out
);
  logic [2:0] cyc_reg, sp_reg;
  logic [15:0] pc_reg;
  logic [15:0] stack_reg [0:7];
  assign last_cycle_out = (cyc_reg + 3'h1 >= instr_len_in);

  always @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cyc_reg <= 3'h0;
      sp_reg <= 3'h0;
      pc_reg <= 16'h0100;
      ret_out <= 1'b0;
    end
    else
    begin
      ret_out <= ret_req_in;
      if (cycle_end_in)
        cyc_reg <= last_cycle_out ? 3'h0 : cyc_reg + 3'h1;
      if (call_start_in)
      begin
        stack_reg[sp_reg] <= pc_reg;
        sp_reg <= sp_reg + 3'h1;
        pc_reg <= vector_in;
      end
      else if (ret_out)
      begin
        sp_reg <= sp_reg - 3'h1;
        pc_reg <= stack_reg[sp_reg - 3'h1];
      end
      else if (cycle_end_in)
        pc_reg <= pc_reg + 16'h0001;
    end
  end
endmodule

// [tb/tb_four_level_irq_controller.sv]
// self-checking bench for the four-level interrupt controller
`timescale 1ns/1ps
module tb_four_level_irq_controller;
  import irq_ctrl_pkg::*;
  localparam int P = 4;
  localparam logic [15:0] VT [4] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b};
  logic clock_in = 1'b0, resetn_in = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, lo = 8'h00, up = 8'h00;
  logic wr = 1'b0, rd = 1'b0, rd_q = 1'b0, pin_a = 1'b1, pin_b = 1'b1, tmr = 1'b0, hb = 1'b0, ret_req = 1'b0;
  logic last, ret, mce, hlc, cs;
  logic [15:0] vec;
  logic [3:0] inp;
  logic [2:0] ilen = 3'h1;
  logic [31:0] seed = 32'h19;
  logic [7:0] rq [$];
  logic [15:0] vq [$];
  int mismatches = 0, n_tests = 0;

  four_level_irq_controller #(.PHASES(P), .SAMPLE_AT(2)) u_dut (.clock_in(clock_in), .resetn_in(resetn_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .ext_request_pin_a_in(pin_a),
    .ext_request_pin_b_in(pin_b), .timer_overflow_in(tmr), .highbyte_overflow_in(hb), .instr_last_cycle_in(last),
    .return_from_interrupt_in(ret), .sample_point_out(), .machine_cycle_end_out(mce),
    .hardware_long_call_out(hlc), .call_start_out(cs), .vector_addr_out(vec), .in_progress_out(inp));
  core_model u_core (.clock_in(clock_in), .resetn_in(resetn_in), .cycle_end_in(mce), .call_start_in(cs),
    .vector_in(vec), .instr_len_in(ilen), .ret_req_in(ret_req), .last_cycle_out(last), .ret_out(ret));

  initial
  begin
    forever #20 clock_in = ~clock_in;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic int lv(input int i);
    return {lo[i], up[i]};
  endfunction

  task automatic chk_rd(input logic [7:0] got);
    logic [7:0] e;
    e = rq.size() ? rq.pop_front() : 8'hxx;
    n_tests++;
    if (e !== got)
    begin
      mismatches++;
      $display("ERROR rdata expected %h seen %h", e, got);
    end
  endtask
  task automatic chk_vec(input logic [15:0] got);
    logic [15:0] e;
    e = vq.size() ? vq.pop_front() : 16'hxxxx;
    n_tests++;
    if (e !== got)
    begin
      mismatches++;
      $display("ERROR vector expected %h seen %h", e, got);
    end
  endtask

  // a call with no note queued is caught as a mismatch
  always @(posedge clock_in)
  begin
    rd_q <= rd;
    if (rd_q === 1'b1)
      chk_rd(rdata);
    if (cs === 1'b1)
      chk_vec(vec);
  end

  task automatic idle(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    idle(1);
    wr <= 1'b0;
    idle(1);
  endtask
  task automatic rd8(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    addr <= a;
    rd <= 1'b1;
    idle(1);
    rd <= 1'b0;
    idle(1);
  endtask
  task automatic fire(input logic [3:0] m);
    pin_a <= pin_a & ~m[0];
    tmr <= m[1];
    pin_b <= pin_b & ~m[2];
    hb <= m[3];
    idle(1);
    tmr <= 1'b0;
    hb <= 1'b0;
    idle(1);
  endtask
  task automatic wait_call(input int lim);
    int n;
    n = 0;
    while (cs !== 1'b1 && n < lim)
    begin
      idle(1);
      n++;
    end
    n_tests++;
    if (n >= lim)
    begin
      mismatches++;
      $display("ERROR call expected 1 seen 0");
    end
    idle(3 * P);
  endtask
  task automatic ret_call;
    ret_req <= 1'b1;
    idle(1);
    ret_req <= 1'b0;
    // short tail: the poll that follows the return is held off, so a waiting source is called no earlier than the poll after that
    idle(2);
  endtask

  // ----------------------------------------------------------------
  // two sources, together or second one during the first routine
  // ----------------------------------------------------------------
  task automatic run(input int a, input int b, input bit gap, input logic [7:0] l, input logic [7:0] u);
    int f, s;
    seed = xs(seed);
    ilen <= {1'b0, seed[1:0]} + 3'h1;
    lo = l;
    up = u;
    wr8(PRIO_LOWER_ADDR, l);
    wr8(PRIO_UPPER_ADDR, u);
    f = (!gap && (lv(b) > lv(a) || (lv(b) == lv(a) && b < a))) ? b : a;
    s = a + b - f;
    vq.push_back(VT[f]);
    fire(gap ? 4'(1 << a) : 4'(1 << a | 1 << b));
    wait_call(9 * P);
    if (gap)
      fire(4'(1 << s));
    if (lv(s) > lv(f))
    begin
      vq.push_back(VT[s]);
      wait_call(40 * P);
      ret_call;
    end
    else
    begin
      idle(6 * P);
      // note first: the waiting source is called only after the return task ends, inside wait_call
      vq.push_back(VT[s]);
      ret_call;
      wait_call(40 * P);
    end
    ret_call;
    pin_a <= 1'b1;
    pin_b <= 1'b1;
    idle(3 * P);
    rd8(STATUS_ADDR, 8'h00);
  endtask

  task automatic give_verdict;
    if (mismatches == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #(40 * 20000);
    mismatches++;
    $display("ERROR run expected done seen timeout");
    give_verdict;
  end

  initial
  begin
    idle(10);
    resetn_in <= 1'b1;
    idle(1);
    rd8(PRIO_UPPER_ADDR, 8'h00);
    rd8(ENABLE_ADDR, 8'h00);
    wr8(PRIO_UPPER_ADDR, 8'hff);
    rd8(PRIO_UPPER_ADDR, 8'h0f);
    seed = xs(seed);
    wr8(PRIO_UPPER_ADDR, seed[7:0]);
    rd8(PRIO_UPPER_ADDR, {4'h0, seed[3:0]});
    rd8(8'h10, 8'h00);
    wr8(PRIO_UPPER_ADDR, 8'h00);
    wr8(ENABLE_ADDR, 8'h0f);
    fire(4'h2);
    pin_a <= 1'b0;
    idle(6 * P);
    wr8(ENABLE_ADDR, 8'h8c);
    idle(6 * P);
    pin_a <= 1'b1;
    idle(3 * P);
    wr8(ENABLE_ADDR, 8'h8d);
    idle(6 * P);
    vq.push_back(VT[1]);
    wr8(ENABLE_ADDR, 8'h8f);
    wait_call(40 * P);
    ret_call;
    vq.push_back(VT[0]);
    pin_a <= 1'b0;
    wait_call(9 * P);
    pin_a <= 1'b1;
    ret_call;
    wr8(FLAG_ADDR, 8'h30);
    rd8(FLAG_ADDR, 8'h30);
    run(1, 3, 1'b0, 8'h08, 8'h08);
    run(1, 3, 1'b0, 8'h00, 8'h00);
    run(0, 2, 1'b0, 8'h00, 8'h00);
    run(0, 2, 1'b0, 8'h04, 8'h00);
    run(1, 0, 1'b1, 8'h00, 8'h01);
    run(3, 2, 1'b1, 8'h08, 8'h0c);
    run(2, 1, 1'b1, 8'h06, 8'h00);
    give_verdict;
  end
endmodule

bind four_level_irq_controller irq_props #(.PHASES(PHASES), .SAMPLE_AT(SAMPLE_AT)) u_props (.clock_in(clock_in),
  .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .instr_last_cycle_in(instr_last_cycle_in), .return_from_interrupt_in(return_from_interrupt_in),
  .sample_point_out(sample_point_out), .machine_cycle_end_out(machine_cycle_end_out),
  .hardware_long_call_out(hardware_long_call_out), .call_start_out(call_start_out),
  .vector_addr_out(vector_addr_out), .in_progress_out(in_progress_out));
